// *** logic/adpc_config_regs.v ***
// input select, crystal output gate, pll ratio and mute status registers
// How it works
// - lock flag includes pcm detect when bit3 set
// - bit2 set: mute output on burst preambles
// - bit0 picks input pin a or b
// - crystal pin driven only when gate and power
// - sixteen bit coarse ratio, reset 0300h
// - 12000k ref, 1/625: ratio table rates
// - 12288k ref, 1/640: same ratio table
// - muted status reads 1 after ramp done
// - lock flag: 1 in lock (with pcm detect too when bit3 set), 0 out
`timescale 1ns/10ps
`include "adpc_defines.vh"
module adpc_config_regs
#(
  parameter RAMP_CYC = `ADPC_MUTE_RAMP_CYC
)
(
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // control port access, already decoded to words
  input  wire        i_wr_stb,
  input  wire        i_rd_stb,
  input  wire [7:0]  i_addr,
  input  wire [15:0] i_wdata,
  output reg  [15:0] o_rdata,
  output reg         o_rvalid,
  // digital audio inputs, pins
  input  wire        i_digital_audio_in_a,
  input  wire        i_digital_audio_in_b,
  output reg         o_slicer_in,
  // decoder state, pins from the decoder domain
  input  wire        i_decoder_lock,
  input  wire        i_pcm_detect,
  input  wire        i_burst_detect,
  input  wire        i_mute_request,
  output reg         o_input_lock_flag,
  output reg         o_mute_active,
  // crystal oscillator
  input  wire        i_xtal_clk,
  input  wire        i_xtal_power_on,
  output wire        o_xtal_out_pin,
  output reg         o_xtal_out_en_n,
  // pll settings
  output reg         o_pll_pullin_adjust,
  output reg  [15:0] o_pll_coarse_ratio
);
  // one-hot mute states
  localparam [2:0] ST_OPEN  = 3'h1;
  localparam [2:0] ST_RAMP  = 3'h2;
  localparam [2:0] ST_MUTED = 3'h4;

  // two stage synchronisers for the audio input and decoder state pins
  reg  [5:0] sync1_reg;
  reg  [5:0] sync2_reg;
  wire [5:0] pins_in = {i_digital_audio_in_a, i_digital_audio_in_b, i_decoder_lock,
                        i_pcm_detect, i_burst_detect, i_mute_request};
  wire       in_a_s   = sync2_reg[5];
  wire       in_b_s   = sync2_reg[4];
  wire       lock_s   = sync2_reg[3];
  wire       pcm_s    = sync2_reg[2];
  wire       burst_s  = sync2_reg[1];
  wire       mreq_s   = sync2_reg[0];

  // store slot map: 0 input, 1 supplemental, 2 coarse
  wire [63:0] words;
  wire [15:0] in_set    = words[15:0];
  wire [15:0] sup_set   = words[31:16];
  wire [15:0] coarse    = words[47:32];
  reg  [1:0]  slot;
  reg         slot_ok;
  wire        stat_sel  = (i_addr == `ADPC_ADDR_INTERP_STAT);
  reg  [15:0] rd_value;  // word picked for the read answer

  // mute state machine
  reg [2:0]  mstate_reg;
  reg [2:0]  mstate_next;
  reg [15:0] ramp_reg;
  reg [15:0] ramp_next;
  wire       want_mute;

  // address decode to store slot
  always @*
  begin
    slot    = 2'h0;
    slot_ok = 1'b1;
    case (i_addr)
      `ADPC_ADDR_INPUT_SET: slot = 2'h0;
      `ADPC_ADDR_SUPPL_SET: slot = 2'h1;
      `ADPC_ADDR_COARSE:    slot = 2'h2;
      default:              slot_ok = 1'b0;
    endcase
  end

  // writable words, reset values held in the store
  adpc_reg_mem #(
    .AW   (2),
    .DW   (16),
    .INIT ({16'h0000, `ADPC_COARSE_RESET, `ADPC_SUP_RESET, `ADPC_IN_RESET})
  ) u_store (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_we      (i_wr_stb & slot_ok),
    .i_waddr   (slot),
    .i_wdata   (i_wdata),
    .i_raddr   (slot),
    .o_rdata   (),            // answer is built from the parallel words
    .o_words   (words)
  );

  // pin synchronisers
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end
    else
    begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
    end
  end

  // mute is wanted on a request or on bursts when auto mute is on
  assign want_mute = mreq_s | (burst_s & in_set[`ADPC_IN_AUTOMUTE_BIT]);

  // next mute state and ramp count
  always @*
  begin
    mstate_next = mstate_reg;
    ramp_next   = ramp_reg;
    case (mstate_reg)
      ST_OPEN:
      begin
        if (want_mute)
        begin
          mstate_next = ST_RAMP;
          ramp_next   = RAMP_CYC[15:0] - 16'h0001;
        end
      end
      ST_RAMP:
      begin
        if (!want_mute)
          mstate_next = ST_OPEN;       // released before the ramp ended
        else if (ramp_reg == 16'h0000)
          mstate_next = ST_MUTED;
        else
          ramp_next = ramp_reg - 16'h0001;
      end
      ST_MUTED:
      begin
        if (!want_mute)
          mstate_next = ST_OPEN;
      end
      default:
        mstate_next = ST_OPEN;
    endcase
  end

  // mute state registers
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mstate_reg <= ST_OPEN;
      ramp_reg   <= 16'h0000;
    end
    else
    begin
      mstate_reg <= mstate_next;
      ramp_reg   <= ramp_next;
    end
  end

  // registered outputs: slicer, lock, mute, pll fields
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_slicer_in         <= 1'b0;
      o_input_lock_flag   <= 1'b0;
      o_mute_active       <= 1'b0;
      o_pll_pullin_adjust <= 1'b0;
      o_pll_coarse_ratio  <= `ADPC_COARSE_RESET;
      o_xtal_out_en_n     <= 1'b1;
    end
    else
    begin
      // input pin choice
      o_slicer_in <= in_set[`ADPC_IN_PIN_BIT] ? in_b_s : in_a_s;
      // lock flag, optionally qualified by pcm detect
      o_input_lock_flag <= lock_s & (pcm_s | ~in_set[`ADPC_IN_COMBINE_BIT]);
      // output muting starts with the ramp
      o_mute_active <= (mstate_next != ST_OPEN);
      // pll controls; supplemental reserved bits are ignored by hardware
      o_pll_pullin_adjust <= sup_set[`ADPC_SUP_PULLIN_BIT];
      o_pll_coarse_ratio  <= coarse;
      // crystal output enable, low while driving
      o_xtal_out_en_n <= ~(sup_set[`ADPC_SUP_XTAL_GATE_BIT] & i_xtal_power_on);
    end
  end

  // crystal pin gated; held low while disabled
  assign o_xtal_out_pin = i_xtal_clk & ~o_xtal_out_en_n;

  // word picked for a read: live status, stored words, zero when unmapped
  always @*
  begin
    rd_value = 16'h0000;
    if (stat_sel)
      rd_value[`ADPC_STAT_MUTED_BIT] = (mstate_reg == ST_MUTED);
    else if (slot_ok)
      rd_value = words[slot*16 +: 16];                          // mapped word
  end

  // read answer one cycle after the strobe; data stand until the next read
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= 16'h0000;
    end
    else
    begin
      o_rvalid <= i_rd_stb;
      if (i_rd_stb)
        o_rdata <= rd_value;  // held so a slow host can still pick it up
    end
  end
endmodule

// *** logic/adpc_defines.vh ***
// register addresses, field positions, reset values and timing counts of the input/pll config bank
`ifndef ADPC_DEFINES_VH
`define ADPC_DEFINES_VH
// register addresses on the control port
`define ADPC_ADDR_INPUT_SET   8'h30
`define ADPC_ADDR_INTERP_STAT 8'h18
`define ADPC_ADDR_SUPPL_SET   8'h40
`define ADPC_ADDR_COARSE      8'h62
// input settings fields
`define ADPC_IN_COMBINE_BIT   3
`define ADPC_IN_AUTOMUTE_BIT  2
`define ADPC_IN_KEEP0_BIT     1
`define ADPC_IN_PIN_BIT       0
`define ADPC_IN_RESET         16'h800C
// supplemental settings fields
`define ADPC_SUP_XTAL_GATE_BIT 15
`define ADPC_SUP_PULLIN_BIT    10
`define ADPC_SUP_RESET         16'h0000
// coarse ratio
`define ADPC_COARSE_RESET     16'h0300
// interpolator status fields
`define ADPC_STAT_MUTED_BIT   2
// mute ramp length, in ns, and derived cycles at 50 ns
`define ADPC_MUTE_RAMP_NS     1600
`define ADPC_CLK_PERIOD_NS    50
`define ADPC_MUTE_RAMP_CYC    ((`ADPC_MUTE_RAMP_NS + `ADPC_CLK_PERIOD_NS - 1) / `ADPC_CLK_PERIOD_NS)
`endif

// *** logic/adpc_reg_mem.v ***
// small register store of the config bank with registered read data
`timescale 1ns/10ps
module adpc_reg_mem
#(
  parameter AW = 2,
  parameter DW = 16,
  parameter [(1<<AW)*DW-1:0] INIT = 64'h0
)
(
  // clock and reset
  input  wire          i_ref_clk,
  input  wire          i_rst,
  // write side
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [DW-1:0] i_wdata,
  // read side
  input  wire [AW-1:0] i_raddr,
  output reg  [DW-1:0] o_rdata,
  // all words in parallel for the control logic
  output wire [(1<<AW)*DW-1:0] o_words
);
  genvar g;
  generate
    for (g = 0; g < (1<<AW); g = g + 1)
    begin : g_word
      reg [DW-1:0] word_reg; // one stored word, one driver per word
      // each word loads its reset value, then takes host writes
      always @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
          word_reg <= INIT[g*DW +: DW];
        else if (i_we && i_waddr == g)
          word_reg <= i_wdata;
      end
      assign o_words[g*DW +: DW] = word_reg;
    end
  endgenerate

  // registered read port
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= {DW{1'b0}};
    else
      o_rdata <= o_words[i_raddr*DW +: DW];
  end
endmodule

// *** sim/adpc_cfg_asserts.sv ***
// port checks of the input and pll config bank
`timescale 1ns/10ps
module adpc_cfg_asserts
(
  input wire        i_ref_clk,
  input wire        i_rst,
  input wire        i_wr_stb,
  input wire        i_rd_stb,
  input wire [7:0]  i_addr,
  input wire [15:0] i_wdata,
  input wire [15:0] o_rdata,
  input wire        o_rvalid,
  input wire        i_xtal_power_on,
  input wire        o_xtal_out_pin,
  input wire        o_xtal_out_en_n,
  input wire        o_pll_pullin_adjust,
  input wire [15:0] o_pll_coarse_ratio
);
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  rd_pulse_a: assert property (o_rvalid == $past(i_rd_stb))
    else $error("read answer timing wrong");
  stat_resv_a: assert property (o_rvalid && $past(i_addr) == 8'h18 |-> o_rdata[15:3] == 13'h0)
    else $error("status high bits not zero");
  stat_low_a: assert property (o_rvalid && $past(i_addr) == 8'h18 |-> o_rdata[1:0] == 2'h0)
    else $error("status low bits not zero");
  unmap_zero_a: assert property (o_rvalid && !($past(i_addr) inside {8'h18, 8'h30, 8'h40, 8'h62})
                                 |-> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  coarse_wr_a: assert property (i_wr_stb && i_addr == 8'h62 |=> ##1 o_pll_coarse_ratio == $past(i_wdata, 2))
    else $error("coarse ratio not stored");
  pullin_wr_a: assert property (i_wr_stb && i_addr == 8'h40 |=> ##1 o_pll_pullin_adjust == $past(i_wdata[10], 2))
    else $error("pull-in bit not stored");
  xtal_pwr_a: assert property (!o_xtal_out_en_n |-> $past(i_xtal_power_on))
    else $error("crystal pin driven without power");
  xtal_off_a: assert property (!i_xtal_power_on && !$past(i_xtal_power_on) |-> !o_xtal_out_pin)
    else $error("crystal signal leaks to pin");
  gate_off_a: assert property (i_wr_stb && i_addr == 8'h40 && !i_wdata[15] ##1 !i_wr_stb |=> ##1 o_xtal_out_en_n)
    else $error("crystal pin driven with gate off");
endmodule
bind adpc_config_regs adpc_cfg_asserts u_chk (
  .i_ref_clk           (i_ref_clk),
  .i_rst               (i_rst),
  .i_wr_stb            (i_wr_stb),
  .i_rd_stb            (i_rd_stb),
  .i_addr              (i_addr),
  .i_wdata             (i_wdata),
  .o_rdata             (o_rdata),
  .o_rvalid            (o_rvalid),
  .i_xtal_power_on     (i_xtal_power_on),
  .o_xtal_out_pin      (o_xtal_out_pin),
  .o_xtal_out_en_n     (o_xtal_out_en_n),
  .o_pll_pullin_adjust (o_pll_pullin_adjust),
  .o_pll_coarse_ratio  (o_pll_coarse_ratio)
);

// *** sim/adpc_host_model.sv ***
// host model of the control port: word writes and reads
`timescale 1ns/10ps
module adpc_host_model
(
  // clock and read answer
  input  wire         i_ref_clk,
  input  wire  [15:0] i_rdata,
  input  wire         i_rvalid,
  // request lines
  output logic        o_wr,
  output logic        o_rd,
  output logic [7:0]  o_addr,
  output logic [15:0] o_data
);
  initial {o_wr, o_rd, o_addr, o_data} = 26'h0;
  // write one word; bits the host must keep at zero are cleared
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    o_wr   <= 1'b1;
    o_addr <= a;
    o_data <= (a == 8'h40) ? (d & 16'h8400) : (a == 8'h30) ? (d & 16'hFFFD) : d;
    @(posedge i_ref_clk);
    o_wr   <= 1'b0;
    o_data <= ~o_data;
  endtask
  // read one word; waits a bounded time for the answer
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_ref_clk);
    o_rd   <= 1'b0;
    repeat (4) if (i_rvalid !== 1'b1) @(posedge i_ref_clk);
    d = i_rdata;
  endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench of the input and pll config bank
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("[ERR] %0t %h %h", $time, g, e); end end
module tb;
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        pa = 1'b0, pb = 1'b0, lk = 1'b0, pcm = 1'b0, bst = 1'b0, xclk = 1'b0, pwr = 1'b0;
  logic        mreq = 1'b0;
  logic        wr, rd, rvalid, slc, lflag, mact, xpin, xen_n, pull;
  logic [7:0]  addr;
  logic [15:0] wd, rdata, rv, cr;
  logic [3:0]  lt [4] = '{4'b1100, 4'b0101, 4'b1111, 4'b0010}; // combine, lock, pcm, flag
  logic [2:0]  xt [3] = '{3'b110, 3'b101, 3'b011};             // gate, power, enable low
  logic [15:0] ratio [6] = '{16'h0140, 16'h01B9, 16'h0372, 16'h0500, 16'h06E4, 16'h0780};
  int          err_total = 0;
  int          checks = 0;
  // 20 MHz clock and a toggling crystal signal
  initial forever #25 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) xclk <= ~xclk;
  adpc_host_model h (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_data(wd));
  adpc_config_regs #(.RAMP_CYC(2)) uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wr_stb(wr), .i_rd_stb(rd),
    .i_addr(addr), .i_wdata(wd), .o_rdata(rdata), .o_rvalid(rvalid), .i_digital_audio_in_a(pa),
    .i_digital_audio_in_b(pb), .o_slicer_in(slc), .i_decoder_lock(lk), .i_pcm_detect(pcm),
    .i_burst_detect(bst), .i_mute_request(mreq), .o_input_lock_flag(lflag), .o_mute_active(mact),
    .i_xtal_clk(xclk), .i_xtal_power_on(pwr), .o_xtal_out_pin(xpin), .o_xtal_out_en_n(xen_n),
    .o_pll_pullin_adjust(pull), .o_pll_coarse_ratio(cr));
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    #100000;
    err_total++;
    complete_run();
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    `CHK({cr, pull, xen_n}, 18'h00C01)
    `CHK(xpin, 1'b0)
    h.rd(8'h18, rv);
    `CHK({rv, mact}, 17'h00000)
    // bursts with auto mute on: ramp, then muted status
    bst <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    h.rd(8'h18, rv);
    `CHK({rv, mact}, 17'h00009)
    h.wr(8'h30, 16'h8008);
    repeat (10) @(posedge i_ref_clk);
    h.rd(8'h18, rv);
    `CHK({rv, mact}, 17'h00000)
    // mute request: status stays 0 during the ramp, 1 once muted
    mreq <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    h.rd(8'h18, rv);
    `CHK({rv, mact}, 17'h00001)
    repeat (4) @(posedge i_ref_clk);
    h.rd(8'h18, rv);
    `CHK({rv, mact}, 17'h00009)
    mreq <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    h.rd(8'h18, rv);
    `CHK({rv, mact}, 17'h00000)
    bst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      h.wr(8'h30, {12'h800, lt[i][3], 3'b000});
      lk  <= lt[i][2];
      pcm <= lt[i][1];
      repeat (6) @(posedge i_ref_clk);
      `CHK(lflag, lt[i][0])
    end
    pa <= 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      h.wr(8'h30, {15'h4000, s[0]});
      repeat (6) @(posedge i_ref_clk);
      `CHK(slc, s == 0)
    end
    for (int i = 0; i < 3; i++)
    begin
      h.wr(8'h40, {xt[i][2], 15'h0});
      pwr <= xt[i][1];
      repeat (4) @(posedge i_ref_clk);
      `CHK(xen_n, xt[i][0])
      // pin follows the crystal while enabled, both phases
      repeat (2)
      begin
        @(posedge i_ref_clk);
        `CHK(xpin, xt[i][0] ? 1'b0 : xclk)
      end
    end
    h.wr(8'h40, 16'h0400);
    repeat (3) @(posedge i_ref_clk);
    `CHK(pull, 1'b1)
    for (int i = 0; i < 6; i++)
    begin
      h.wr(8'h62, ratio[i]);
      repeat (3) @(posedge i_ref_clk);
      `CHK(cr, ratio[i])
    end
    // reset in mid run brings the reset words back
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    `CHK({cr, pull, xen_n}, 18'h00C01)
    repeat (3) @(posedge i_ref_clk);
    `CHK(slc, 1'b1)
    h.wr(8'h62, 16'h0300);
    repeat (3) @(posedge i_ref_clk);
    `CHK(cr, 16'h0300)
    h.wr(8'h18, 16'hFFFF);
    h.rd(8'h18, rv);
    `CHK(rv, 16'h0000)
    h.rd(8'h55, rv);
    `CHK(rv, 16'h0000)
    complete_run();
  end
endmodule
